// File: hdl/spc_parity.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// R1 - checking enabled: odd-parity check each received byte
// R2 - checking off: no errors, parity still generated
// R3 - even select: 0 odd, 1 even outgoing
// R4 - initiator with attention enable: raise ATN
// R5 - detected scsi parity error sets status flag
// R6 - interrupt only when parity-error enable set
// R7 - halt enable: halt on error, both roles
// R8 - halt disabled, target: stop at transfer end
// R9 - live low/high parity line status bits
// R10 - latched odd parity per captured lane
// R11 - master parity check only when enabled
// R12 - target-signalled error sets master status
// R13 - masked master error sets status, no irq
// R14 - check incoming pci bytes against byte pins
// R15 - drive generated byte parity on pins
// R16 - byte parity error: fatal, stop script processor
// R17 - masked byte error sets status, no irq
// R18 - standard pci parity untouched; host drives pins
// R19 - parity computed separately per eight-bit lane
module spc_parity (
	input  wire logic                  SYS_CLK,       // 10 MHz device clock
	input  wire logic                  RST_N,         // synchronous reset, active low
	input  wire logic [3:0]            REG_ADDR,      // register index
	input  wire logic [7:0]            REG_WDATA,     // write data
	input  wire logic                  REG_WR,        // write strobe
	input  wire logic                  REG_RD,        // read strobe
	output logic      [7:0]            REG_RDATA,     // read data, cycle after strobe
	input  wire logic                  SCSI_PAR_PIN0, // raw low parity line level
	input  wire logic                  SCSI_PAR_PIN1, // raw high parity line level
	input  wire logic                  RX_STROBE,     // input latch captured a word
	input  wire spc_pkg::spc_scsi_rx_t RX_WORD,       // captured word
	input  wire logic                  TX_STROBE,     // outgoing word presented
	input  wire logic [15:0]           TX_DATA,       // outgoing data
	output logic      [1:0]            TX_PAR,        // generated scsi parity
	input  wire logic                  IS_INITIATOR,  // 1 initiator, 0 target
	input  wire logic                  XFER_DONE,     // current transfer finished
	input  wire logic                  ATN_RELEASE,   // phase logic drops attention
	input  wire logic                  HALT_ACK,      // phase logic resumes
	output logic                       SCSI_ATN,      // attention request
	output logic                       SCSI_HALT,     // stop scsi operation
	input  wire logic                  MASTER_PHASE,  // own master data phase
	input  wire logic                  TARGET_PERR,   // target signalled parity error
	input  wire logic                  PCI_IN_VALID,  // master read / slave write data
	input  wire spc_pkg::spc_pci_word_t PCI_IN,       // incoming ad and byte parity
	input  wire logic                  PCI_OUT_VALID, // master write / slave read data
	input  wire logic [31:0]           PCI_AD_OUT,    // outgoing ad
	output logic      [3:0]            PCI_BPAR_OUT,  // generated byte parity
	output logic                       PCI_BPAR_OE,   // byte parity pins driven
	output logic                       SCRIPT_STOP,   // fatal stop of script processor
	output logic                       IRQ            // interrupt request, active high
);
	import spc_pkg::*;

	// odd parity bit for one byte: makes the nine-bit total odd
	function automatic logic odd_bit(input logic [7:0] b);
		odd_bit = ~(^b);
	endfunction : odd_bit

	// pci byte parity: even over byte plus parity bit
	function automatic logic even_bit(input logic [7:0] b);
		even_bit = ^b;
	endfunction : even_bit

	// control registers
	logic [7:0] ctrl_a;         // check enable, attention enable
	logic [7:0] ctrl_b;         // parity sense, halt disable
	logic [7:0] ien_a;          // scsi parity interrupt enable
	logic [7:0] test_d;         // master parity check enable
	logic [7:0] dma_ien;        // dma interrupt enables

	// status flags
	logic       scsi_pe;        // sticky scsi parity error
	logic       mdpe;           // sticky master data parity error
	logic       byte_pe;        // sticky byte parity error
	logic [1:0] latch_par;      // odd parity of captured lanes

	// pin synchronisers, three stages each
	logic [1:0] par_s1;         // first stage, read only by second
	logic [1:0] par_s2;         // second stage
	logic [1:0] par_s3;         // third stage
	logic [1:0] live_par;       // accepted line level

	// decoded controls
	logic       chk_en;         // scsi checking on
	logic       atn_en;         // attention on error
	logic       even_sel;       // even outgoing sense
	logic       dis_halt;       // target-mode halt deferred
	logic       halt_pending;   // target halt waiting for transfer end

	// per-lane check results
	logic [1:0] lane_bad;       // lane mismatch
	logic       scsi_err;       // one-cycle error event
	logic [3:0] byte_bad;       // pci lane mismatch
	logic       bp_err;         // one-cycle byte parity event
	logic       mdpe_evt;       // one-cycle master error event
	logic       wr_ist;         // write to scsi interrupt status a
	logic       wr_dst;         // write to dma status

	assign chk_en   = ctrl_a[BIT_PAR_CHK_EN];
	assign atn_en   = ctrl_a[BIT_ATN_ON_ERR];
	assign even_sel = ctrl_b[BIT_EVEN_PAR];
	assign dis_halt = ctrl_b[BIT_DIS_HALT];
	assign wr_ist   = REG_WR && (REG_ADDR == OFF_SCSI_IST_A);
	assign wr_dst   = REG_WR && (REG_ADDR == OFF_DMA_STAT);

	// lane checks; high lane only counts on wide words
	always_comb begin
		lane_bad[0] = (odd_bit(RX_WORD.data[7:0]) != RX_WORD.par[0]);            // R19
		lane_bad[1] = RX_WORD.wide
			&& (odd_bit(RX_WORD.data[15:8]) != RX_WORD.par[1]);                    // R19
		scsi_err    = RX_STROBE && chk_en && (lane_bad != 2'b00);                 // R1 R2
	end

	// pci byte checks; PAR itself is checked elsewhere and never consulted here
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			byte_bad[i] = (even_bit(PCI_IN.ad[8*i +: 8]) != PCI_IN.bpar[i]);        // R14
		end
		bp_err   = PCI_IN_VALID && (byte_bad != 4'h0);                            // R14 R18
		mdpe_evt = MASTER_PHASE && TARGET_PERR && test_d[BIT_MASTER_PE_EN];       // R11
	end

	// software-written control registers
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			ctrl_a  <= RST_CTRL_A;
			ctrl_b  <= RST_CTRL_B;
			ien_a   <= RST_IEN;
			test_d  <= RST_TEST_D;
			dma_ien <= RST_IEN;
		end else if (REG_WR) begin
			unique case (REG_ADDR)
				OFF_SCSI_CTRL_A: ctrl_a  <= REG_WDATA;
				OFF_SCSI_CTRL_B: ctrl_b  <= REG_WDATA;
				OFF_SCSI_IEN_A:  ien_a   <= REG_WDATA;
				OFF_CHIP_TEST_D: test_d  <= REG_WDATA;
				OFF_DMA_IEN:     dma_ien <= REG_WDATA;
				default: begin
					// status and unmapped writes leave controls alone
				end
			endcase
		end
	end

	// live parity line synchroniser; a level counts once stages two and three agree
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			par_s1   <= 2'h0;
			par_s2   <= 2'h0;
			par_s3   <= 2'h0;
			live_par <= 2'h0;
		end else begin
			par_s1 <= {SCSI_PAR_PIN1, SCSI_PAR_PIN0};
			par_s2 <= par_s1;
			par_s3 <= par_s2;
			for (int i = 0; i < 2; i++) begin
				if (par_s2[i] == par_s3[i]) begin
					live_par[i] <= par_s3[i];                                       // R9
				end
			end
		end
	end

	// latched parity follows each captured word, odd sense regardless of checking
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			latch_par <= 2'h0;
		end else if (RX_STROBE) begin
			latch_par[0] <= odd_bit(RX_WORD.data[7:0]);                             // R10
			latch_par[1] <= odd_bit(RX_WORD.data[15:8]);                            // R10
		end
	end

	// scsi parity error flag; write one clears, a new error wins over the clear
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			scsi_pe <= 1'b0;
		end else if (scsi_err) begin
			scsi_pe <= 1'b1;                                                        // R5
		end else if (wr_ist && REG_WDATA[BIT_SCSI_PE]) begin
			scsi_pe <= 1'b0;
		end
	end

	// dma-side error flags, same set-over-clear priority
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			mdpe    <= 1'b0;
			byte_pe <= 1'b0;
		end else begin
			if (mdpe_evt) begin
				mdpe <= 1'b1;                                                       // R12
			end else if (wr_dst && REG_WDATA[BIT_MDPE]) begin
				mdpe <= 1'b0;
			end
			if (bp_err) begin
				byte_pe <= 1'b1;                                                    // R16
			end else if (wr_dst && REG_WDATA[BIT_BYTE_PE]) begin
				byte_pe <= 1'b0;
			end
		end
	end

	// outgoing scsi parity per lane, sense from the select bit, always generated
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			TX_PAR <= 2'h0;
		end else if (TX_STROBE) begin
			TX_PAR[0] <= odd_bit(TX_DATA[7:0]) ^ even_sel;                          // R2 R3 R19
			TX_PAR[1] <= odd_bit(TX_DATA[15:8]) ^ even_sel;                         // R3 R19
		end
	end

	// attention: initiator only, held until the phase logic releases it
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			SCSI_ATN <= 1'b0;
		end else if (scsi_err && atn_en && IS_INITIATOR) begin
			SCSI_ATN <= 1'b1;                                                       // R4
		end else if (ATN_RELEASE) begin
			SCSI_ATN <= 1'b0;
		end
	end

	// halt: at once unless a target has halting deferred to transfer end
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			SCSI_HALT    <= 1'b0;
			halt_pending <= 1'b0;
		end else begin
			if (scsi_err && (!dis_halt || IS_INITIATOR)) begin
				SCSI_HALT <= 1'b1;                                                  // R7
			end else if (halt_pending && XFER_DONE) begin
				SCSI_HALT <= 1'b1;                                                  // R8
			end else if (HALT_ACK) begin
				SCSI_HALT <= 1'b0;
			end
			// deferred request survives until the transfer completes
			if (scsi_err && dis_halt && !IS_INITIATOR) begin
				halt_pending <= 1'b1;                                               // R8
			end else if (XFER_DONE) begin
				halt_pending <= 1'b0;
			end
		end
	end

	// pci byte parity generation on outgoing phases; host must accept the pins
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			PCI_BPAR_OUT <= 4'h0;
			PCI_BPAR_OE  <= 1'b0;
		end else begin
			PCI_BPAR_OE <= PCI_OUT_VALID;                                           // R15 R18
			for (int i = 0; i < 4; i++) begin
				PCI_BPAR_OUT[i] <= even_bit(PCI_AD_OUT[8*i +: 8]);                  // R15
			end
		end
	end

	// fatal stop follows the byte error flag; masking the interrupt does not lift it
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			SCRIPT_STOP <= 1'b0;
		end else begin
			SCRIPT_STOP <= byte_pe || bp_err;                                      // R16
		end
	end

	// interrupt request, each source gated by its own enable
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= (scsi_pe && ien_a[BIT_SCSI_PE])                                  // R6
				|| (mdpe && dma_ien[BIT_MDPE])                                      // R13
				|| (byte_pe && dma_ien[BIT_BYTE_PE]);                               // R17
		end
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			unique case (REG_ADDR)
				OFF_SCSI_CTRL_A: REG_RDATA <= ctrl_a;
				OFF_SCSI_CTRL_B: REG_RDATA <= ctrl_b;
				OFF_SCSI_IEN_A:  REG_RDATA <= ien_a;
				OFF_SCSI_IST_A:  REG_RDATA <= {7'h00, scsi_pe};
				OFF_SCSI_STAT_A: REG_RDATA <= {7'h00, live_par[0]};                // R9
				OFF_SCSI_STAT_B: REG_RDATA <= {4'h0, latch_par[0], 3'h0};          // R10
				OFF_SCSI_STAT_C: REG_RDATA <= {4'h0, latch_par[1], 2'h0, live_par[1]};
				OFF_CHIP_TEST_D: REG_RDATA <= test_d;
				OFF_DMA_STAT:    REG_RDATA <= {1'b0, mdpe, 4'h0, byte_pe, 1'b0};
				OFF_DMA_IEN:     REG_RDATA <= dma_ien;
				default:         REG_RDATA <= 8'h00;
			endcase
		end else begin
			// only one cycle of valid data after a read
			REG_RDATA <= 8'h00;
		end
	end

endmodule : spc_parity

// File: include/spc_pkg.sv
// shared constants and carriers for the scsi/pci parity block
package spc_pkg;

	// register bus geometry
	localparam int ADDR_W = 4;                 // register index width
	localparam int DATA_W = 8;                 // register data width

	// register offsets
	localparam logic [3:0] OFF_SCSI_CTRL_A  = 4'h0;  // scsi_control_reg_a
	localparam logic [3:0] OFF_SCSI_CTRL_B  = 4'h1;  // scsi_control_reg_b
	localparam logic [3:0] OFF_SCSI_IEN_A   = 4'h2;  // scsi_interrupt_enable_a
	localparam logic [3:0] OFF_SCSI_IST_A   = 4'h3;  // scsi_interrupt_status_a
	localparam logic [3:0] OFF_SCSI_STAT_A  = 4'h4;  // scsi_status_a
	localparam logic [3:0] OFF_SCSI_STAT_B  = 4'h5;  // scsi_status_b
	localparam logic [3:0] OFF_SCSI_STAT_C  = 4'h6;  // scsi_status_c
	localparam logic [3:0] OFF_CHIP_TEST_D  = 4'h7;  // chip_test_reg_d
	localparam logic [3:0] OFF_DMA_STAT     = 4'h8;  // dma_status_reg
	localparam logic [3:0] OFF_DMA_IEN      = 4'h9;  // dma_interrupt_enable_reg

	// field positions
	localparam int BIT_ATN_ON_ERR   = 1;  // scsi_control_reg_a
	localparam int BIT_PAR_CHK_EN   = 3;  // scsi_control_reg_a
	localparam int BIT_EVEN_PAR     = 2;  // scsi_control_reg_b
	localparam int BIT_DIS_HALT     = 5;  // scsi_control_reg_b
	localparam int BIT_SCSI_PE      = 0;  // interrupt enable and interrupt status a
	localparam int BIT_LIVE_PAR     = 0;  // status a (low) and c (high)
	localparam int BIT_LATCH_PAR    = 3;  // status b (low) and c (high)
	localparam int BIT_MASTER_PE_EN = 3;  // chip_test_reg_d
	localparam int BIT_MDPE         = 6;  // dma status / enable
	localparam int BIT_BYTE_PE      = 1;  // dma status / enable

	// reset values
	localparam logic [7:0] RST_CTRL_A = 8'h00;  // checking off
	localparam logic [7:0] RST_CTRL_B = 8'h00;  // odd sense, halt enabled
	localparam logic [7:0] RST_IEN    = 8'h00;  // all interrupts masked
	localparam logic [7:0] RST_TEST_D = 8'h00;  // master check off

	// received scsi word from the input latch logic
	typedef struct packed {
		logic [15:0] data;    // two byte lanes
		logic [1:0]  par;     // parity lines, low lane in bit 0
		logic        wide;    // high lane valid
	} spc_scsi_rx_t;

	// one pci data phase towards or from the pins
	typedef struct packed {
		logic [31:0] ad;      // address/data
		logic [3:0]  bpar;    // per-byte parity
	} spc_pci_word_t;

endpackage : spc_pkg

// File: bench/spc_far_end.sv
`timescale 1ns/1ps
// far side: scsi sender and pci host, parity made for the words the bench asks for
module spc_far_end (
	input  wire logic [15:0]           rx_data, // scsi word to send
	input  wire logic [1:0]            rx_bad,  // lanes sent with wrong parity
	input  wire logic                  rx_wide, // high lane valid
	input  wire logic [31:0]           pci_ad,  // incoming pci data phase
	input  wire logic [3:0]            pci_bad, // byte pins sent wrong
	output spc_pkg::spc_scsi_rx_t      rx_word, // to the input latch
	output spc_pkg::spc_pci_word_t     pci_in   // to the pci pins
);
	import spc_pkg::*;

	// odd sense per lane, bad lanes inverted on purpose
	assign rx_word = '{data: rx_data, wide: rx_wide,
		par: {~^rx_data[15:8], ~^rx_data[7:0]} ^ rx_bad};

	// host drives each byte pin with even parity, like the pci parity line, inverted for bytes set in pci_bad
	always_comb begin
		pci_in.ad = pci_ad;
		for (int i = 0; i < 4; i++)
			pci_in.bpar[i] = ^pci_ad[8*i +: 8] ^ pci_bad[i];
	end
endmodule : spc_far_end

// File: bench/spc_parity_chk.sv
`timescale 1ns/1ps
// watches the parity block from its pins only
module spc_parity_chk (
	input wire logic                   SYS_CLK,       // device clock
	input wire logic                   RST_N,         // sync reset
	input wire logic                   REG_RD,        // read strobe
	input wire logic                   REG_WR,        // write strobe
	input wire logic [7:0]             REG_RDATA,     // read data
	input wire logic                   RX_STROBE,     // word captured
	input wire spc_pkg::spc_scsi_rx_t  RX_WORD,       // captured word
	input wire logic                   TX_STROBE,     // word sent
	input wire logic [15:0]            TX_DATA,       // sent data
	input wire logic [1:0]             TX_PAR,        // sent parity
	input wire logic                   IS_INITIATOR,  // role
	input wire logic                   XFER_DONE,     // transfer end
	input wire logic                   SCSI_ATN,      // attention
	input wire logic                   SCSI_HALT,     // halt
	input wire logic                   MASTER_PHASE,  // master phase
	input wire logic                   TARGET_PERR,   // target error
	input wire logic                   PCI_IN_VALID,  // incoming phase
	input wire spc_pkg::spc_pci_word_t PCI_IN,        // incoming word
	input wire logic                   PCI_OUT_VALID, // outgoing phase
	input wire logic [31:0]            PCI_AD_OUT,    // outgoing data
	input wire logic [3:0]             PCI_BPAR_OUT,  // byte parity
	input wire logic                   PCI_BPAR_OE,   // byte pins driven
	input wire logic                   SCRIPT_STOP,   // fatal stop
	input wire logic                   IRQ            // interrupt
);
	import spc_pkg::*;

	// causes recomputed from the pins; a bad scsi lane only allows, a bad pci byte forces the stop
	logic       rx_bad;  // some valid lane fails odd parity
	logic       pci_bad; // some byte fails even parity
	logic [3:0] out_par; // even parity of outgoing bytes
	logic [1:0] tx_odd;  // odd parity of outgoing lanes
	assign rx_bad  = ~^{RX_WORD.data[7:0], RX_WORD.par[0]}
		| (RX_WORD.wide & ~^{RX_WORD.data[15:8], RX_WORD.par[1]});
	assign pci_bad = ^{PCI_IN.ad[7:0], PCI_IN.bpar[0]} | ^{PCI_IN.ad[15:8], PCI_IN.bpar[1]}
		| ^{PCI_IN.ad[23:16], PCI_IN.bpar[2]} | ^{PCI_IN.ad[31:24], PCI_IN.bpar[3]};
	assign out_par = {^PCI_AD_OUT[31:24], ^PCI_AD_OUT[23:16], ^PCI_AD_OUT[15:8], ^PCI_AD_OUT[7:0]};
	assign tx_odd  = {~^TX_DATA[15:8], ~^TX_DATA[7:0]};

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	a_tx_sense: assert property (
		TX_STROBE |=> ((TX_PAR ^ $past(tx_odd)) inside {2'b00, 2'b11}))
		else $error("tx lanes carry different parity sense");
	a_tx_hold: assert property (
		!TX_STROBE |=> $stable(TX_PAR)) else $error("tx parity moved without strobe");
	a_bpar_gen: assert property (
		PCI_OUT_VALID |=> PCI_BPAR_OE && PCI_BPAR_OUT == $past(out_par))
		else $error("byte parity out wrong");
	a_bpar_release: assert property (
		!PCI_OUT_VALID |=> !PCI_BPAR_OE) else $error("byte pins driven when idle");
	a_atn_cause: assert property (
		$rose(SCSI_ATN) |-> $past(RX_STROBE && rx_bad && IS_INITIATOR))
		else $error("attention without initiator error");
	a_halt_cause: assert property (
		$rose(SCSI_HALT) |-> $past(RX_STROBE && rx_bad) || $past(XFER_DONE))
		else $error("halt without cause");
	a_stop_on_err: assert property (
		PCI_IN_VALID && pci_bad |=> SCRIPT_STOP) else $error("byte error did not stop");
	// the stop trails the cleared flag by one cycle, so a write one cycle back excuses it
	a_stop_holds: assert property (
		SCRIPT_STOP && !REG_WR && !$past(REG_WR) |=> SCRIPT_STOP)
		else $error("stop dropped without clear");
	a_irq_cause: assert property (
		$rose(IRQ) |-> $past(REG_WR) || $past(REG_WR, 2) || $past(RX_STROBE && rx_bad, 2)
		|| $past(MASTER_PHASE && TARGET_PERR, 2) || $past(PCI_IN_VALID && pci_bad, 2)
		|| $past(PCI_IN_VALID && pci_bad, 3)) else $error("interrupt without cause");
	a_rdata_idle: assert property (
		!REG_RD |=> REG_RDATA == 8'h00) else $error("read data outside its cycle");
endmodule : spc_parity_chk

bind spc_parity spc_parity_chk u_chk (.*);

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import spc_pkg::*;
	// design pins, same names so the instance connects by name
	logic          SYS_CLK, RST_N, REG_WR, REG_RD, RX_STROBE, TX_STROBE, IS_INITIATOR;
	logic          SCSI_PAR_PIN0, SCSI_PAR_PIN1, XFER_DONE, ATN_RELEASE, HALT_ACK;
	logic          SCSI_ATN, SCSI_HALT, MASTER_PHASE, TARGET_PERR, PCI_IN_VALID;
	logic          PCI_OUT_VALID, PCI_BPAR_OE, SCRIPT_STOP, IRQ, rx_wide;
	logic [3:0]    REG_ADDR, PCI_BPAR_OUT, pci_bad;
	logic [7:0]    REG_WDATA, REG_RDATA;
	logic [15:0]   TX_DATA, rx_data;
	logic [1:0]    TX_PAR, rx_bad;
	logic [31:0]   PCI_AD_OUT, pci_ad;
	spc_scsi_rx_t  RX_WORD;
	spc_pci_word_t PCI_IN;
	int            num_errors, n_compared;

	spc_parity dut (.*);
	spc_far_end u_far (.rx_data(rx_data), .rx_bad(rx_bad), .rx_wide(rx_wide),
		.pci_ad(pci_ad), .pci_bad(pci_bad), .rx_word(RX_WORD), .pci_in(PCI_IN));

	// free running clock, 100 ns
	initial begin
		SYS_CLK = 1'b0;
		forever #50 SYS_CLK = ~SYS_CLK;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic flg(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask : flg
	// register cycles: strobe for one cycle, read data sampled the cycle after
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		{REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge SYS_CLK);
		{REG_RD, REG_ADDR} <= {1'b1, a};
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
	endtask : rd
	task automatic send_rx(input logic [15:0] d, input logic [1:0] b, input logic w);
		@(posedge SYS_CLK);
		{RX_STROBE, rx_data, rx_bad, rx_wide} <= {1'b1, d, b, w};
		@(posedge SYS_CLK);
		RX_STROBE <= 1'b0;
		#1;
	endtask : send_rx
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask : wait_cyc
	// clear status, drop attention and halt together
	task automatic clear_scsi;
		wr(OFF_SCSI_IST_A, 8'h01);
		@(posedge SYS_CLK);
		{ATN_RELEASE, HALT_ACK} <= 2'b11;
		@(posedge SYS_CLK);
		{ATN_RELEASE, HALT_ACK} <= 2'b00;
		wait_cyc(2);
		flg(SCSI_ATN | SCSI_HALT | IRQ, 1'b0);
	endtask : clear_scsi

	task automatic t_regs;
		logic [7:0] v;
		rd(OFF_SCSI_CTRL_A, v); chk(v, RST_CTRL_A);
		rd(OFF_SCSI_CTRL_B, v); chk(v, RST_CTRL_B);
		rd(OFF_CHIP_TEST_D, v); chk(v, RST_TEST_D);
		wr(OFF_SCSI_CTRL_B, 8'h24);
		rd(OFF_SCSI_CTRL_B, v); chk(v, 8'h24);
		rd(4'hF, v); chk(v, 8'h00);
	endtask : t_regs
	// both senses, checking off: parity is still generated per lane
	task automatic t_tx;
		logic [15:0] d;
		for (int e = 0; e < 2; e++) begin
			wr(OFF_SCSI_CTRL_B, e[0] ? 8'h04 : 8'h00);
			for (int k = 0; k < 2; k++) begin
				d = k[0] ? 16'h0103 : 16'h8000;
				@(posedge SYS_CLK);
				{TX_STROBE, TX_DATA} <= {1'b1, d};
				@(posedge SYS_CLK);
				TX_STROBE <= 1'b0;
				#1 chk({6'h00, TX_PAR}, {6'h00, {~^d[15:8], ~^d[7:0]} ^ {2{e[0]}}});
			end
		end
	endtask : t_tx
	task automatic t_rx_off;
		logic [7:0] v;
		send_rx(16'h0000, 2'b01, 1'b0);
		flg(SCSI_HALT, 1'b0);
		rd(OFF_SCSI_IST_A, v); chk(v, 8'h00);
	endtask : t_rx_off
	task automatic t_rx_init;
		logic [7:0] v;
		@(posedge SYS_CLK);
		IS_INITIATOR <= 1'b1;
		wr(OFF_SCSI_CTRL_A, 8'h0A);
		wr(OFF_SCSI_IEN_A, 8'h01);
		send_rx(16'h5B3C, 2'b10, 1'b1);
		flg(SCSI_ATN, 1'b1);
		flg(SCSI_HALT, 1'b1);
		wait_cyc(1);
		flg(IRQ, 1'b1);
		rd(OFF_SCSI_IST_A, v); flg(v[BIT_SCSI_PE], 1'b1);
		rd(OFF_SCSI_STAT_B, v); flg(v[BIT_LATCH_PAR], ~^8'h3C);
		rd(OFF_SCSI_STAT_C, v); flg(v[BIT_LATCH_PAR], ~^8'h5B);
		clear_scsi;
	endtask : t_rx_init
	// masked interrupt; a bad high lane on a narrow word is no error
	task automatic t_rx_mask;
		logic [7:0] v;
		wr(OFF_SCSI_IEN_A, 8'h00);
		send_rx(16'h00FF, 2'b10, 1'b0);
		flg(SCSI_HALT, 1'b0);
		send_rx(16'h0001, 2'b01, 1'b0);
		wait_cyc(3);
		flg(IRQ, 1'b0);
		rd(OFF_SCSI_IST_A, v); chk(v, 8'h01);
		clear_scsi;
	endtask : t_rx_mask
	// target with halt disabled waits for the end of the transfer
	task automatic t_target;
		@(posedge SYS_CLK);
		IS_INITIATOR <= 1'b0;
		wr(OFF_SCSI_CTRL_B, 8'h20);
		send_rx(16'h0000, 2'b01, 1'b0);
		flg(SCSI_HALT | SCSI_ATN, 1'b0);
		@(posedge SYS_CLK);
		XFER_DONE <= 1'b1;
		@(posedge SYS_CLK);
		XFER_DONE <= 1'b0;
		wait_cyc(1);
		flg(SCSI_HALT, 1'b1);
		clear_scsi;
	endtask : t_target
	task automatic t_live;
		logic [7:0] v;
		for (int k = 0; k < 2; k++) begin
			@(posedge SYS_CLK);
			{SCSI_PAR_PIN0, SCSI_PAR_PIN1} <= {~k[0], k[0]};
			wait_cyc(6);
			rd(OFF_SCSI_STAT_A, v); flg(v[BIT_LIVE_PAR], ~k[0]);
			rd(OFF_SCSI_STAT_C, v); flg(v[BIT_LIVE_PAR], k[0]);
		end
	endtask : t_live
	task automatic pci_rx(input logic [31:0] ad, input logic [3:0] bad);
		@(posedge SYS_CLK);
		{PCI_IN_VALID, pci_ad, pci_bad, MASTER_PHASE, TARGET_PERR} <= {1'b1, ad, bad, 2'b11};
		@(posedge SYS_CLK);
		{PCI_IN_VALID, MASTER_PHASE, TARGET_PERR} <= 3'b000;
		#1;
	endtask : pci_rx
	task automatic t_pci;
		logic [7:0] v;
		pci_rx(32'h8040_2010, 4'h0);
		flg(SCRIPT_STOP, 1'b0);
		rd(OFF_DMA_STAT, v); chk(v, 8'h00);
		wr(OFF_CHIP_TEST_D, 8'h08);
		pci_rx(32'h8040_2010, 4'h4);
		flg(SCRIPT_STOP, 1'b1);
		wait_cyc(3);
		flg(IRQ, 1'b0);
		rd(OFF_DMA_STAT, v); chk(v, 8'h42);
		wr(OFF_DMA_IEN, 8'h02);
		wait_cyc(3);
		flg(IRQ, 1'b1);
		wr(OFF_DMA_STAT, 8'h42);
		wait_cyc(2);
		flg(SCRIPT_STOP | IRQ, 1'b0);
		@(posedge SYS_CLK);
		{PCI_OUT_VALID, PCI_AD_OUT} <= {1'b1, 32'h0102_0307};
		@(posedge SYS_CLK);
		PCI_OUT_VALID <= 1'b0;
		#1 chk({4'h0, PCI_BPAR_OUT}, 8'h0D);
		flg(PCI_BPAR_OE, 1'b1);
	endtask : t_pci

	task automatic test_done;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	// main sequence after two reset cycles
	initial begin
		{RST_N, REG_WR, REG_RD, RX_STROBE, TX_STROBE, IS_INITIATOR, SCSI_PAR_PIN0} = '0;
		{SCSI_PAR_PIN1, XFER_DONE, ATN_RELEASE, HALT_ACK, MASTER_PHASE, TARGET_PERR} = '0;
		{PCI_IN_VALID, PCI_OUT_VALID, rx_wide, REG_ADDR, pci_bad, REG_WDATA} = '0;
		{TX_DATA, rx_data, rx_bad, PCI_AD_OUT, pci_ad} = '0;
		repeat (2) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		t_regs;
		t_tx;
		t_rx_off;
		t_rx_init;
		t_rx_mask;
		t_target;
		t_live;
		t_pci;
		test_done;
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		num_errors++;
		test_done;
	end
endmodule : tb_top
